// >>> design/bstc_top.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose : Four-wire test access port controller with its test registers.
// Assumes : Test pins arrive asynchronously and are oversampled by sys_clk,
//           which must run well above four times the test clock.
// Notes   : Boundary chain updates also stream into a snapshot FIFO.
//////////////////////////////////////////////////////////////////////////////
module bstc_top #(
    parameter int SNAP_DEPTH = bstc_pkg::SNAP_DEPTH
) (
    input  wire logic                     sys_clk,
    input  wire logic                     resetn,
    // Test port pins
    input  wire logic                     tck,
    input  wire logic                     tms,
    input  wire logic                     tdi,
    input  wire logic                     tdiDriven,
    output logic                          tdo,
    output logic                          tdoOeN,
    // Device pins observed by the boundary chain
    input  wire logic [bstc_pkg::BS_W-1:0] pinSense,
    // Applied test values and mode
    output logic      [bstc_pkg::BS_W-1:0] pinDrive,
    output logic      [bstc_pkg::CT_W-1:0] testOpControl,
    output logic      [bstc_pkg::IR_W-1:0] activeInstr,
    output logic                          testMode,
    output logic                          runningTest,
    // Snapshot stream of boundary chain updates
    output logic                          snapValid,
    input  wire logic                     snapReady,
    output logic      [bstc_pkg::BS_W-1:0] snapData,
    output logic                          snapRoom,
    output logic                          snapOverflow
);
    import bstc_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic             tckMeta, tckSync, tckLast;
    logic             tmsMeta, tmsSync;
    logic             tdiMeta, tdiSync;
    logic             drvMeta, drvSync;
    logic [BS_W-1:0]  pinMeta, pinSync;

    // Two flops on every pin before any logic looks at it
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tckMeta <= 1'b0;
            tckSync <= 1'b0;
            tckLast <= 1'b0;
            tmsMeta <= 1'b1;
            tmsSync <= 1'b1;
            tdiMeta <= 1'b1;
            tdiSync <= 1'b1;
            drvMeta <= 1'b0;
            drvSync <= 1'b0;
            pinMeta <= BS_RESET;
            pinSync <= BS_RESET;
        end else begin
            tckMeta <= tck;
            tckSync <= tckMeta;
            tckLast <= tckSync;
            tmsMeta <= tms;
            tmsSync <= tmsMeta;
            tdiMeta <= tdi;
            tdiSync <= tdiMeta;
            drvMeta <= tdiDriven;
            drvSync <= drvMeta;
            pinMeta <= pinSense;
            pinSync <= pinMeta;
        end
    end

    // Edge enables; both pins settle a cycle ahead of the clock edge
    wire tckRise = tckSync && !tckLast;
    wire tckFall = !tckSync && tckLast;
    // Pad pull-up modelled by forcing a floating input high
    wire tdiBit  = drvSync ? tdiSync : 1'b1;

    //////////////////////////////////////////////////////////////////////////
    // Controller state machine

    bstc_state_t state;
    bstc_state_t next_state;

    // Standard graph; TMS high from anywhere reaches reset in five
    function automatic bstc_state_t step(input bstc_state_t s,
                                         input logic m);
        case (s)
            ST_RESET:  step = m ? ST_RESET  : ST_IDLE;
            ST_IDLE:   step = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: step = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: step = m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  step = m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: step = m ? ST_UP_DR  : ST_PA_DR;
            ST_PA_DR:  step = m ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: step = m ? ST_UP_DR  : ST_SH_DR;
            ST_UP_DR:  step = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: step = m ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: step = m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  step = m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: step = m ? ST_UP_IR  : ST_PA_IR;
            ST_PA_IR:  step = m ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: step = m ? ST_UP_IR  : ST_SH_IR;
            ST_UP_IR:  step = m ? ST_SEL_DR : ST_IDLE;
            default:   step = ST_RESET;
        endcase
    endfunction : step

    assign next_state = step(state, tmsSync);

    // Advance only on the sampled rising test-clock edge
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_RESET;
        end else if (tckRise) begin
            state <= next_state;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // State and instruction decode

    wire inReset  = (state == ST_RESET);
    wire inIdle   = (state == ST_IDLE);
    wire capDr    = (state == ST_CAP_DR);
    wire shDr     = (state == ST_SH_DR);
    wire upDr     = (state == ST_UP_DR);
    wire capIr    = (state == ST_CAP_IR);
    wire shIr     = (state == ST_SH_IR);
    wire upIr     = (state == ST_UP_IR);

    // Shift stages and latches of the four test registers
    logic [IR_W-1:0] irShift;
    logic [IR_W-1:0] irActive;
    logic [BS_W-1:0] bsShift;
    logic [BS_W-1:0] bsLatch;
    logic [CT_W-1:0] ctShift;
    logic [CT_W-1:0] ctLatch;
    logic            bypassBit;

    // One data register selected; unknown opcodes fall back to bypass
    wire selBs     = (irActive == OP_BOUNDARY) || (irActive == OP_RUNTEST);
    wire selCt     = (irActive == OP_CONTROL);
    wire selBypass = !selBs && !selCt;

    // Serial output of whichever register sits in the path
    wire scanOut = shIr ? irShift[0] :
                   selBs ? bsShift[0] :
                   selCt ? ctShift[0] : bypassBit;

    //////////////////////////////////////////////////////////////////////////
    // Instruction register

    // Shift stage: capture status, shift toward the LSB
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irShift <= IR_RESET;
        end else if (tckRise) begin
            if (inReset)
                irShift <= IR_RESET;
            else if (capIr)
                irShift <= IR_CAPTURE;
            else if (shIr)
                irShift <= {tdiBit, irShift[IR_W-1:1]};
        end
    end

    // Active instruction changes on the falling edge in Update-IR
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irActive <= IR_RESET;
        end else if (inReset) begin
            irActive <= IR_RESET;
        end else if (tckFall && upIr) begin
            irActive <= irShift;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Data registers: capture and shift on the rising edge

    // Bypass captures zero and is a lone shift stage
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bypassBit <= 1'b0;
        end else if (tckRise && selBypass) begin
            if (capDr)
                bypassBit <= 1'b0;
            else if (shDr)
                bypassBit <= tdiBit;
        end
    end

    // Boundary chain samples the pins, shifted from bit 39 toward bit 0
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bsShift <= BS_RESET;
        end else if (tckRise) begin
            if (inReset)
                bsShift <= BS_RESET;
            else if (capDr && selBs)
                bsShift <= pinSync;
            else if (shDr && selBs)
                bsShift <= {tdiBit, bsShift[BS_W-1:1]};
        end
    end

    // Control chain captures its update latch, then shifts
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctShift <= CT_RESET;
        end else if (tckRise) begin
            if (inReset)
                ctShift <= CT_RESET;
            else if (capDr && selCt)
                ctShift <= ctLatch;
            else if (shDr && selCt)
                ctShift <= {tdiBit, ctShift[CT_W-1:1]};
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Test operations in Run-Test/Idle

    function automatic logic [BS_W-1:0] lfsr(input logic [BS_W-1:0] v);
        lfsr = {v[BS_W-2:0], ^(v & LFSR_TAPS)};
    endfunction : lfsr

    wire [CT_OP_W-1:0] testOp  = ctLatch[CT_OP_LSB +: CT_OP_W];
    // Masking zeroes the sensed inputs before compression
    wire [BS_W-1:0]    psaIn   = ctLatch[CT_MASK_BIT] ? BS_RESET : pinSync;
    // Only RUNTEST in Idle runs anything; other states just hold
    wire               runNow  = inIdle && (irActive == OP_RUNTEST);
    wire [BS_W-1:0]    runNext =
        (testOp == TOP_COUNT) ? bsLatch + 1'b1 :
        (testOp == TOP_PSA)   ? lfsr(bsLatch) ^ psaIn :
        (testOp == TOP_PRPG)  ? lfsr(bsLatch) : bsLatch;

    //////////////////////////////////////////////////////////////////////////
    // Update latches on the falling edge; run-test steps bsLatch on the rising edge

    // Snapshot push is refused while the FIFO is full
    wire snapPush = tckFall && upDr && selBs;
    wire fifoInReady;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bsLatch <= BS_RESET;
        end else if (inReset) begin
            bsLatch <= BS_RESET;
        end else if (snapPush) begin
            bsLatch <= bsShift;
        end else if (tckRise && runNow) begin
            bsLatch <= runNext;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctLatch <= CT_RESET;
        end else if (inReset) begin
            ctLatch <= CT_RESET;
        end else if (tckFall && upDr && selCt) begin
            ctLatch <= ctShift;
        end
    end

    // Lost snapshot is sticky until the port goes through reset state
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            snapOverflow <= 1'b0;
        end else if (snapPush && !fifoInReady) begin
            snapOverflow <= 1'b1;
        end else if (inReset) begin
            snapOverflow <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Serial output, changed only on the falling edge

    // Drives the LSB from the first fall in Shift, floats in Exit1 onward
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tdo    <= 1'b0;
            tdoOeN <= 1'b1;
        end else if (tckFall) begin
            tdo    <= scanOut;
            tdoOeN <= !(shDr || shIr);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Mode outputs

    // Normal function while in reset state or under bypass
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            testMode    <= 1'b0;
            runningTest <= 1'b0;
        end else begin
            testMode    <= !inReset && !selBypass;
            runningTest <= runNow && (testOp != TOP_NONE);
        end
    end

    assign pinDrive      = bsLatch;
    assign testOpControl = ctLatch;
    assign activeInstr   = irActive;
    assign snapRoom      = fifoInReady;

    //////////////////////////////////////////////////////////////////////////
    // Snapshot buffer

    bstc_fifo #(
        .WIDTH (BS_W),
        .DEPTH (SNAP_DEPTH)
    ) u_snap (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .inValid  (snapPush),
        .inReady  (fifoInReady),
        .inData   (bsShift),
        .outValid (snapValid),
        .outReady (snapReady),
        .outData  (snapData)
    );

endmodule : bstc_top

// >>> common/bstc_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose : Shared constants and types of the boundary-scan test port.
// Assumes : All widths match the test registers of the scanned device.
// Notes   : Opcodes other than the reset value are local assignments.
//////////////////////////////////////////////////////////////////////////////
package bstc_pkg;

    // Register lengths
    localparam int IR_W  = 8;
    localparam int BS_W  = 40;
    localparam int CT_W  = 11;

    // Values loaded on reset and capture
    localparam logic [IR_W-1:0] IR_RESET   = 8'hFF;
    localparam logic [IR_W-1:0] IR_CAPTURE = 8'h81;
    localparam logic [BS_W-1:0] BS_RESET   = 40'h00_0000_0000;
    localparam logic [CT_W-1:0] CT_RESET   = 11'h002;

    // Instruction opcodes, even parity in bit 7
    localparam logic [IR_W-1:0] OP_BYPASS   = 8'hFF;
    localparam logic [IR_W-1:0] OP_BOUNDARY = 8'h82;
    localparam logic [IR_W-1:0] OP_CONTROL  = 8'h87;
    localparam logic [IR_W-1:0] OP_RUNTEST  = 8'h09;

    // Test operation field of the control chain
    localparam int CT_OP_LSB   = 0;
    localparam int CT_OP_W     = 2;
    localparam int CT_MASK_BIT = 2;
    localparam logic [CT_OP_W-1:0] TOP_NONE  = 2'h0;
    localparam logic [CT_OP_W-1:0] TOP_COUNT = 2'h1;
    localparam logic [CT_OP_W-1:0] TOP_PSA   = 2'h2;
    localparam logic [CT_OP_W-1:0] TOP_PRPG  = 2'h3;

    // Feedback taps of the signature and pattern generator
    localparam logic [BS_W-1:0] LFSR_TAPS = 40'h80_0000_0038;

    // Snapshot buffer depth
    localparam int SNAP_DEPTH = 8;

    // Controller states, one-hot
    typedef enum logic [15:0] {
        ST_RESET   = 16'h0001,
        ST_IDLE    = 16'h0002,
        ST_SEL_DR  = 16'h0004,
        ST_CAP_DR  = 16'h0008,
        ST_SH_DR   = 16'h0010,
        ST_EX1_DR  = 16'h0020,
        ST_PA_DR   = 16'h0040,
        ST_EX2_DR  = 16'h0080,
        ST_UP_DR   = 16'h0100,
        ST_SEL_IR  = 16'h0200,
        ST_CAP_IR  = 16'h0400,
        ST_SH_IR   = 16'h0800,
        ST_EX1_IR  = 16'h1000,
        ST_PA_IR   = 16'h2000,
        ST_EX2_IR  = 16'h4000,
        ST_UP_IR   = 16'h8000
    } bstc_state_t;

endpackage : bstc_pkg

// >>> design/bstc_fifo.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose : Small synchronous FIFO with valid/ready on both sides.
// Assumes : Single clock, asynchronous active-low reset.
// Notes   : Simultaneous push and pop on a full FIFO is refused on push.
//////////////////////////////////////////////////////////////////////////////
module bstc_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    wire              push = inValid && inReady;
    wire              pop  = outValid && outReady;

    // Honest flags from the occupancy count
    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
    endfunction : bump

    // Storage write, no reset needed on data
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) wrPtr <= bump(wrPtr);
            if (pop)  rdPtr <= bump(rdPtr);
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : bstc_fifo

// >>> dv/bstc_properties.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose : Port-level properties of the test port controller.
// Assumes : Single sys_clk domain, resetn asynchronous active low.
// Notes   : Test clock falls are found from a raw history of the pin.
module bstc_properties (
    input wire logic                      sys_clk,
    input wire logic                      resetn,
    input wire logic                      tck,
    input wire logic                      tdo,
    input wire logic                      tdoOeN,
    input wire logic [bstc_pkg::IR_W-1:0] activeInstr,
    input wire logic [bstc_pkg::CT_W-1:0] testOpControl,
    input wire logic [bstc_pkg::BS_W-1:0] pinDrive,
    input wire logic                      testMode,
    input wire logic                      runningTest,
    input wire logic                      snapValid,
    input wire logic                      snapReady,
    input wire logic [bstc_pkg::BS_W-1:0] snapData,
    input wire logic                      snapRoom,
    input wire logic                      snapOverflow
);
    timeunit 1ns;
    timeprecision 100ps;
    import bstc_pkg::*;

    logic [7:0] tckHist;
    // Window of eight edges: design lags a pin fall by up to four
    wire        fellLately = |(tckHist[7:1] & ~tckHist[6:0]);

    // Raw tck history, newest sample in bit 0
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) tckHist <= 8'h00;
        else tckHist <= {tckHist[6:0], tck};
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_stall;
        snapValid && !snapReady;
    endsequence

    a_tdo_on_fall : assert property (
        ($changed(tdoOeN) || ($changed(tdo) && !tdoOeN)) |-> fellLately)
        else $error("tdo moved away from a test clock fall");
    a_instr_on_fall : assert property (
        $changed(activeInstr) && activeInstr != IR_RESET |-> fellLately)
        else $error("instruction changed away from a fall");
    a_drive_on_fall : assert property (
        $changed(pinDrive) && pinDrive != BS_RESET |-> fellLately)
        else $error("pin drive changed away from a fall");
    a_ctl_on_fall : assert property (
        $changed(testOpControl) && testOpControl != CT_RESET |-> fellLately)
        else $error("control latch changed away from a fall");
    a_reset_values : assert property (
        $rose(resetn) |-> activeInstr == IR_RESET && pinDrive == BS_RESET
            && testOpControl == CT_RESET && tdoOeN && !testMode)
        else $error("wrong values after reset");
    a_bypass_quiet : assert property (
        $past(activeInstr) == OP_BYPASS && activeInstr == OP_BYPASS
            |-> !testMode)
        else $error("test mode while bypass is active");
    a_run_needs_op : assert property (
        runningTest |-> activeInstr == OP_RUNTEST
            && testOpControl[CT_OP_W-1:0] != TOP_NONE)
        else $error("test running without its instruction");
    a_overflow_full : assert property (
        $rose(snapOverflow) |-> !$past(snapRoom))
        else $error("overflow flagged with room left");
    a_snap_holds : assert property (
        s_stall |=> $stable(snapData) && snapValid)
        else $error("snapshot head lost while stalled");
endmodule : bstc_properties

bind bstc_top bstc_properties u_bstc_properties (
    .sys_clk(sys_clk), .resetn(resetn), .tck(tck), .tdo(tdo),
    .tdoOeN(tdoOeN), .activeInstr(activeInstr),
    .testOpControl(testOpControl), .pinDrive(pinDrive),
    .testMode(testMode), .runningTest(runningTest),
    .snapValid(snapValid), .snapReady(snapReady), .snapData(snapData),
    .snapRoom(snapRoom), .snapOverflow(snapOverflow));

// >>> dv/bstc_host_model.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose : Test bus controller driving the four-wire port.
// Assumes : tck period of eight sys_clk cycles, 200 ns.
// Notes   : tck rests low between calls; released lines wander.
module bstc_host_model (
    input  wire logic sys_clk,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      tdiDriven,
    input  wire logic tdo,
    input  wire logic tdoOeN
);
    timeunit 1ns;
    timeprecision 100ps;

    logic lastTdo;

    // Idle pin levels
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
        tdiDriven = 1'h1;
        lastTdo = 1'h0;
    end

    // One test clock cycle; tdo is read late in the high phase
    task automatic step(input logic tmsV, input logic tdiV,
                        output logic seen);
        tms = tmsV;
        tdi = tdiDriven ? tdiV : ~tdi;
        repeat (4) @(posedge sys_clk);
        #1 tck = 1'h1;
        repeat (4) @(posedge sys_clk);
        #1 seen = tdoOeN ? ~lastTdo : tdo;
        lastTdo = seen;
        tck = 1'h0;
    endtask : step

    // Scan from idle and back, LSB first
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic b;
        dout = '0;
        step(1'h1, ~tdi, b);
        if (ir) step(1'h1, ~tdi, b);
        step(1'h0, ~tdi, b);
        step(1'h0, ~tdi, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'h1, ~tdi, b);
        step(1'h0, ~tdi, b);
    endtask : scan

    // Forced reset by tms high, then into idle
    task automatic to_idle();
        logic b;
        repeat (5) step(1'h1, ~tdi, b);
        step(1'h0, ~tdi, b);
    endtask : to_idle
endmodule : bstc_host_model

// >>> dv/tb_top.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose : Self-checking bench of the test port controller.
// Assumes : Host model drives the port, bench drives the rest.
// Notes   : Expectations come from the package constants and hand-worked literals.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import bstc_pkg::*;

    logic            sys_clk, resetn, tck, tms, tdi, tdiDriven;
    logic            tdo, tdoOeN, testMode, runningTest, snapReady;
    logic            snapValid, snapRoom, snapOverflow;
    logic [BS_W-1:0] pinSense, pinDrive, snapData;
    logic [CT_W-1:0] testOpControl;
    logic [IR_W-1:0] activeInstr;
    int              fails = 0;
    int              checked = 0;
    int              cyc = 0;

    bstc_top u_bstc_top (
        .sys_clk(sys_clk), .resetn(resetn), .tck(tck), .tms(tms),
        .tdi(tdi), .tdiDriven(tdiDriven), .tdo(tdo), .tdoOeN(tdoOeN),
        .pinSense(pinSense), .pinDrive(pinDrive),
        .testOpControl(testOpControl), .activeInstr(activeInstr),
        .testMode(testMode), .runningTest(runningTest),
        .snapValid(snapValid), .snapReady(snapReady), .snapData(snapData),
        .snapRoom(snapRoom), .snapOverflow(snapOverflow));

    bstc_host_model u_bstc_host_model (
        .sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi),
        .tdiDriven(tdiDriven), .tdo(tdo), .tdoOeN(tdoOeN));

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("Counts: %0d checked, %0d failed", checked, fails);
        if (fails == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out

    task automatic t_reset();
        chk(activeInstr, IR_RESET);
        chk(pinDrive, BS_RESET);
        chk(testOpControl, CT_RESET);
        chk({testMode, tdoOeN, snapValid}, 3'h2);
        $display("test reset done");
    endtask : t_reset

    task automatic t_ir();
        logic [63:0] d;
        u_bstc_host_model.to_idle();
        u_bstc_host_model.scan(1'h1, IR_W, 64'(OP_BOUNDARY), d);
        chk(d[IR_W-1:0], IR_CAPTURE);
        chk(activeInstr, OP_BOUNDARY);
        chk(testMode, 1'h1);
        $display("test instruction scan done");
    endtask : t_ir

    // Nine updates into an eight-word buffer, then drain it
    task automatic t_fifo();
        logic [63:0]     d;
        logic [BS_W-1:0] v;
        for (int k = 0; k < 9; k++) begin
            v = 40'h3C_0000_0000 | 40'(k);
            u_bstc_host_model.scan(1'h0, BS_W, 64'(v), d);
            if (k == 0) chk(d[BS_W-1:0], pinSense);
            chk(pinDrive, v);
        end
        chk({snapRoom, snapOverflow}, 2'h1);
        for (int k = 0; k < 8; k++) begin
            chk({snapValid, snapData},
                {1'h1, 40'h3C_0000_0000 | 40'(k)});
            snapReady = 1'h1;
            @(posedge sys_clk) #1 snapReady = 1'h0;
            @(posedge sys_clk) #1;
        end
        chk(snapValid, 1'h0);
        $display("test boundary and buffer done");
    endtask : t_fifo

    // Control chain, run-test in idle, then reset from mid Shift-DR
    task automatic t_control();
        logic [63:0] d;
        u_bstc_host_model.scan(1'h1, IR_W, 64'(OP_CONTROL), d);
        u_bstc_host_model.scan(1'h0, CT_W, 64'h001, d);
        chk(d[CT_W-1:0], CT_RESET);
        chk(testOpControl, 11'h001);
        chk(runningTest, 1'h0);
        u_bstc_host_model.scan(1'h1, IR_W, 64'(OP_RUNTEST), d);
        chk(runningTest, 1'h1);
        u_bstc_host_model.step(1'h1, 1'h0, d[0]);
        chk(pinDrive, 40'h3C_0000_0009);
        chk(runningTest, 1'h0);
        for (int k = 0; k < 3; k++) u_bstc_host_model.step(1'h0, 1'h0, d[0]);
        u_bstc_host_model.to_idle();
        chk(activeInstr, IR_RESET);
        chk(testOpControl, CT_RESET);
        chk({pinDrive, snapOverflow}, 41'h0);
        $display("test control and forced reset done");
    endtask : t_control

    // Bypass opcode and an unknown one, second with tdi left open
    task automatic t_bypass();
        logic [63:0]     d;
        logic [IR_W-1:0] ops [2] = '{OP_BYPASS, 8'h00};
        for (int k = 0; k < 2; k++) begin
            u_bstc_host_model.scan(1'h1, IR_W, 64'(ops[k]), d);
            u_bstc_host_model.tdiDriven = (k == 0);
            u_bstc_host_model.scan(1'h0, 4, 64'h5, d);
            chk(d[3:0], k == 0 ? 4'hA : 4'hE);
            chk(testMode, 1'h0);
            u_bstc_host_model.tdiDriven = 1'h1;
        end
        $display("test bypass done");
    endtask : t_bypass

    // Clock
    initial begin
        sys_clk = 1'h0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Hang guard, well above the expected run
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end

    // Main sequence
    initial begin
        resetn = 1'h0;
        snapReady = 1'h0;
        pinSense = 40'hA5_1234_5678;
        repeat (5) @(posedge sys_clk);
        #1 resetn = 1'h1;
        t_reset();
        t_ir();
        t_fifo();
        t_control();
        t_bypass();
        close_out();
    end
endmodule : tb_top
